// file: timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// Register addresses (byte offsets)
`define ADDR_A_CONTROL 8'h16
`define ADDR_B_CONTROL 8'h17
`define ADDR_A_PERIOD 8'h18
`define ADDR_B_PERIOD 8'h19
`define ADDR_A_PULSE 8'h1a
`define ADDR_B_PULSE 8'h1b
`define ADDR_IRQ_STATUS 8'h1c
`define ADDR_IRQ_MASK 8'h1d
`define ADDR_COUNT_A 8'h1e
`define ADDR_COUNT_B 8'h1f
// Control field positions
`define CTL_FLOP_BIT 7
`define CTL_CLK_HI 6
`define CTL_CLK_LO 4
`define CTL_RUN_BIT 3
`define CTL_MODE_HI 2
`define CTL_MODE_LO 0
// Reset values
`define CONTROL_RESET 8'h00
`define PERIOD_RESET 8'hff
`define PULSE_RESET 8'hff
// Prescaler taps
`define TAP_FAST_11 11
`define TAP_FAST_7 7
`define TAP_FAST_5 5
`define TAP_FAST_3 3
`define TAP_FAST_1 1
`define TAP_SLOW_3 3
`define PRESCALE_WIDTH 12
`endif

// file: timer_pkg.sv
`default_nettype none
package timer_pkg;
  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_DIVIDER = 3'h1,
    MODE_PWM = 3'h2,
    MODE_CASCADE = 3'h3
  } mode_t;
  typedef enum logic [2:0] {
    SUB_TIMER = 3'h4,
    SUB_WARMUP = 3'h5,
    SUB_PWM16 = 3'h6,
    SUB_PPG16 = 3'h7
  } sub_mode_t;
  typedef enum logic [2:0] {
    CLK_DIV11 = 3'h0,
    CLK_DIV7 = 3'h1,
    CLK_DIV5 = 3'h2,
    CLK_DIV3 = 3'h3,
    CLK_SLOW = 3'h4,
    CLK_DIV1 = 3'h5,
    CLK_FAST = 3'h6,
    CLK_PIN = 3'h7
  } clk_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;
endpackage : timer_pkg
`default_nettype wire

// file: timer_tick_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.svh"
// Free-running prescalers turned into one-cycle enables
module timer_tick_select (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow_osc_clock,
  input wire logic timer_a_pin,
  input wire logic timer_b_pin,
  input wire logic divider_tap_select,
  input wire logic low_speed,
  input wire logic [2:0] selA,
  input wire logic [2:0] selB,
  output logic tickA,
  output logic tickB
);
  typedef struct packed {
    logic [`PRESCALE_WIDTH-1:0] fastCnt;
    logic [3:0] slowCnt;
    logic slowPrev;
    logic pinAPrev;
    logic pinBPrev;
    logic tickA;
    logic tickB;
  } state_t;
  state_t st_r;
  state_t st_nxt;
  logic slowEdge;
  logic [`PRESCALE_WIDTH-1:0] fastRise;
  logic [3:0] slowRise;

  // Rising edge of a divider bit gives a one-cycle enable at its rate
  // Bit n-1 of a free counter rises once in 2^n cycles, hence the minus one
  function automatic logic pick(input logic [2:0] sel, input logic pinEdge,
    input logic [`PRESCALE_WIDTH-1:0] fr, input logic [3:0] sr, input logic se,
    input logic useSlow);
    logic r;
    r = 1'b0;
    case (sel)
      timer_pkg::CLK_DIV11: r = useSlow ? sr[`TAP_SLOW_3 - 1] : fr[`TAP_FAST_11 - 1]; // R5
      timer_pkg::CLK_DIV7: r = fr[`TAP_FAST_7 - 1];
      timer_pkg::CLK_DIV5: r = fr[`TAP_FAST_5 - 1];
      timer_pkg::CLK_DIV3: r = fr[`TAP_FAST_3 - 1];
      timer_pkg::CLK_SLOW: r = se;
      timer_pkg::CLK_DIV1: r = fr[`TAP_FAST_1 - 1];
      timer_pkg::CLK_FAST: r = 1'b1;
      default: r = pinEdge;
    endcase
    return r;
  endfunction : pick

  // Next state of counters and edge history
  always_comb
  begin
    st_nxt = st_r;
    slowEdge = slow_osc_clock & ~st_r.slowPrev;
    st_nxt.fastCnt = st_r.fastCnt + 1'b1;
    st_nxt.slowPrev = slow_osc_clock;
    st_nxt.pinAPrev = timer_a_pin;
    st_nxt.pinBPrev = timer_b_pin;
    if (slowEdge)
    begin
      st_nxt.slowCnt = st_r.slowCnt + 1'b1;
    end
    fastRise = st_nxt.fastCnt & ~st_r.fastCnt;
    slowRise = slowEdge ? (st_nxt.slowCnt & ~st_r.slowCnt) : 4'h0;
    // Registered enables; one cycle of latency costs a prescaler nothing
    st_nxt.tickA = pick(selA, timer_a_pin & ~st_r.pinAPrev, fastRise, slowRise, slowEdge,
      divider_tap_select | low_speed);
    st_nxt.tickB = pick(selB, timer_b_pin & ~st_r.pinBPrev, fastRise, slowRise, slowEdge,
      divider_tap_select | low_speed);
  end

  // State register; edge history resets low, so an input already high at reset release reads as an edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Enables leave straight from the state register
  assign tickA = st_r.tickA;
  assign tickB = st_r.tickB;
endmodule : timer_tick_select
`default_nettype wire

// file: dual_timer.sv
// Function
// R1: Each unit has a control register, period compare and pulse-width compare register.
// R2: Run bit zero stops and clears the counter; one starts counting.
// R3: Mode 000 timer, 001 divider output, 010 PWM output.
// R4: Mode 011 cascades both units into 16 bits; top-bit codes reserved.
// R5: Clock select picks fast taps, slow, or pin; 000 slow/8 when selected.
// R6: Software uses undivided fast clock in low speed only for warm-up.
// R7: Software keeps mode, clock and flop fields while running.
// R8: Stop write leaves mode, clock and flop fields unchanged.
// R9: Start write may set mode, clock and flop; new values take effect.
// R10: Software never writes the period while running.
// R11: Pulse width may change while running only in PWM modes.
// R12: Cascade needs first mode 011, sub-mode from second unit.
// R13: Cascade counting clock comes from first unit's clock select.
// R14: Cascade run and flop init come from the second unit.
// R15: First control register resets to zero.
// R16: Cascade upper sub-modes clock second unit from first overflow.
// R17: Flop init bit loads the output flip-flop when counting starts.
// R18: Each unit is an 8-bit up counter compared with its period.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.svh"
module dual_timer #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic slow_osc_clock,
  input wire logic timer_a_pin,
  input wire logic timer_b_pin,
  input wire logic divider_tap_select,
  input wire logic low_speed,
  output logic timer_a_out,
  output logic timer_b_out,
  output logic irq
);
  // Whole block state: registers, counters, flops and bus answer in one word
  typedef struct packed {
    // Software-visible registers
    logic [7:0] ctlA;
    logic [7:0] ctlB;
    logic [WIDTH-1:0] perA;
    logic [WIDTH-1:0] perB;
    logic [WIDTH-1:0] pwA;
    logic [WIDTH-1:0] pwB;
    // Live counters and output flops
    logic [WIDTH-1:0] cntA;
    logic [WIDTH-1:0] cntB;
    logic ffA;
    logic ffB;
    // Interrupt bookkeeping, bit 0 unit A, bit 1 unit B
    logic [1:0] status;
    logic [1:0] mask;
    // Run phase per unit; idle holds the counter clear
    timer_pkg::run_state_t stA;
    timer_pkg::run_state_t stB;
    logic [7:0] rdata;
    logic irq;
  } state_t;
  state_t st_r;
  state_t st_nxt;
  // Prescaler enables and decoded control fields
  logic tickA;
  logic tickB;
  logic [2:0] selA;
  logic [2:0] selB;
  logic cascade;
  logic runA;
  logic runB;
  logic ovfA;
  logic ovfB;
  logic [2:0] modeA;
  logic [2:0] modeB;
  logic [WIDTH-1:0] ctlWr;

  // Field pickers shared by both units
  function automatic logic [2:0] modeOf(input logic [7:0] c);
    return c[`CTL_MODE_HI:`CTL_MODE_LO];
  endfunction : modeOf

  function automatic logic [2:0] clkOf(input logic [7:0] c);
    return c[`CTL_CLK_HI:`CTL_CLK_LO];
  endfunction : clkOf

  function automatic logic runOf(input logic [7:0] c);
    return c[`CTL_RUN_BIT];
  endfunction : runOf

  function automatic logic flopOf(input logic [7:0] c);
    return c[`CTL_FLOP_BIT];
  endfunction : flopOf

  // The 16-bit PWM code means PWM only on the upper half of a cascade;
  // on the first unit that code is reserved and must not toggle the output
  function automatic logic isPwm(input logic [2:0] m, input logic casc);
    return casc ? (m == timer_pkg::SUB_PWM16) : (m == timer_pkg::MODE_PWM);
  endfunction : isPwm

  // Source selection, cascade routing
  always_comb
  begin
    cascade = modeOf(st_r.ctlA) == timer_pkg::MODE_CASCADE; // R4 R12
    modeA = modeOf(st_r.ctlA);
    modeB = modeOf(st_r.ctlB);
    selA = clkOf(st_r.ctlA); // R13
    selB = clkOf(st_r.ctlB);
    // In a cascade one run bit starts both halves in the same cycle
    runA = cascade ? runOf(st_r.ctlB) : runOf(st_r.ctlA); // R14
    runB = runOf(st_r.ctlB);
    ctlWr = wdata;
  end

  // Prescaler and edge detection; enables trail their source by one cycle
  timer_tick_select u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .slow_osc_clock(slow_osc_clock),
    .timer_a_pin(timer_a_pin),
    .timer_b_pin(timer_b_pin),
    .divider_tap_select(divider_tap_select),
    .low_speed(low_speed),
    .selA(selA),
    .selB(selB),
    .tickA(tickA),
    .tickB(tickB)
  );

  // Counting, compare, registers and read-back
  always_comb
  begin
    st_nxt = st_r;
    // Overflow strobes last one cycle; they feed status and the cascade
    ovfA = 1'b0;
    ovfB = 1'b0;
    // Unit A: stopped counter is held clear
    unique case (st_r.stA)
      timer_pkg::ST_IDLE:
      begin
        st_nxt.cntA = '0; // R2
        if (runA)
        begin
          st_nxt.stA = timer_pkg::ST_RUN;
          st_nxt.ffA = cascade ? flopOf(st_r.ctlB) : flopOf(st_r.ctlA); // R17 R14
        end
      end
      timer_pkg::ST_RUN:
      begin
        if (!runA)
        begin
          st_nxt.stA = timer_pkg::ST_IDLE;
          st_nxt.cntA = '0; // R2
        end
        else if (tickA)
        begin
          if (st_r.cntA == st_r.perA) // R18
          begin
            st_nxt.cntA = '0;
            ovfA = 1'b1;
            if (modeA == timer_pkg::MODE_DIVIDER)
            begin
              st_nxt.ffA = ~st_r.ffA; // R3
            end
          end
          else
          begin
            st_nxt.cntA = st_r.cntA + 1'b1;
          end
          // PWM: output flips at pulse-width match
          if (isPwm(modeA, 1'b0) && st_r.cntA == st_r.pwA) // R3
          begin
            st_nxt.ffA = ~st_r.ffA;
          end
        end
      end
      default:
      begin
        st_nxt.stA = timer_pkg::ST_IDLE;
      end
    endcase
    // Unit B: cascaded upper sub-modes count A overflows
    unique case (st_r.stB)
      timer_pkg::ST_IDLE:
      begin
        st_nxt.cntB = '0;
        if (runB)
        begin
          st_nxt.stB = timer_pkg::ST_RUN;
          st_nxt.ffB = flopOf(st_r.ctlB); // R17
        end
      end
      timer_pkg::ST_RUN:
      begin
        if (!runB)
        begin
          st_nxt.stB = timer_pkg::ST_IDLE;
          st_nxt.cntB = '0; // R2
        end
        else if ((cascade && modeB[2]) ? ovfA : tickB) // R16
        begin
          if (st_r.cntB == st_r.perB)
          begin
            st_nxt.cntB = '0;
            ovfB = 1'b1;
            if (modeB == timer_pkg::MODE_DIVIDER || cascade)
            begin
              st_nxt.ffB = ~st_r.ffB;
            end
          end
          else
          begin
            st_nxt.cntB = st_r.cntB + 1'b1;
          end
          if (isPwm(modeB, cascade) && st_r.cntB == st_r.pwB)
          begin
            st_nxt.ffB = ~st_r.ffB;
          end
        end
      end
      default:
      begin
        st_nxt.stB = timer_pkg::ST_IDLE;
      end
    endcase
    // Register writes; start write may carry new fields
    if (wr)
    begin
      unique case (addr)
        `ADDR_A_CONTROL: st_nxt.ctlA = ctlWr; // R9
        `ADDR_B_CONTROL: st_nxt.ctlB = ctlWr; // R9
        `ADDR_A_PERIOD: st_nxt.perA = ctlWr; // R1
        `ADDR_B_PERIOD: st_nxt.perB = ctlWr;
        `ADDR_A_PULSE: st_nxt.pwA = ctlWr; // R11
        `ADDR_B_PULSE: st_nxt.pwB = ctlWr;
        `ADDR_IRQ_MASK: st_nxt.mask = ctlWr[1:0];
        default:
        begin
        end
      endcase
    end
    // Sticky status: new event wins over write-one clear
    st_nxt.status = st_r.status;
    if (wr && addr == `ADDR_IRQ_STATUS)
    begin
      st_nxt.status = st_r.status & ~ctlWr[1:0];
    end
    st_nxt.status = st_nxt.status | {ovfB, ovfA & ~cascade};
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    // Read data valid the cycle after the strobe; unmapped reads zero
    st_nxt.rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        `ADDR_A_CONTROL: st_nxt.rdata = st_r.ctlA;
        `ADDR_B_CONTROL: st_nxt.rdata = st_r.ctlB;
        `ADDR_A_PERIOD: st_nxt.rdata = st_r.perA;
        `ADDR_B_PERIOD: st_nxt.rdata = st_r.perB;
        `ADDR_A_PULSE: st_nxt.rdata = st_r.pwA;
        `ADDR_B_PULSE: st_nxt.rdata = st_r.pwB;
        `ADDR_IRQ_STATUS: st_nxt.rdata = {6'h00, st_r.status};
        `ADDR_IRQ_MASK: st_nxt.rdata = {6'h00, st_r.mask};
        `ADDR_COUNT_A: st_nxt.rdata = st_r.cntA;
        `ADDR_COUNT_B: st_nxt.rdata = st_r.cntB;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.ctlA <= `CONTROL_RESET; // R15
      st_r.ctlB <= `CONTROL_RESET;
      st_r.perA <= `PERIOD_RESET;
      st_r.perB <= `PERIOD_RESET;
      st_r.pwA <= `PULSE_RESET;
      st_r.pwB <= `PULSE_RESET;
      st_r.stA <= timer_pkg::ST_IDLE;
      st_r.stB <= timer_pkg::ST_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Every output is a state field, no logic after the flops
  assign rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign timer_a_out = st_r.ffA;
  assign timer_b_out = st_r.ffB;
endmodule : dual_timer
`default_nettype wire

// file: dual_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dual_timer_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic timer_a_out,
  input wire logic irq
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Read port answers only after a strobe
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata moved without a read");
  a_unmapped_zero: assert property (rd && (addr < 8'h16 || addr > 8'h1f) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Written fields are kept as written
  a_ctl_readback: assert property (wr && addr == 8'h16 ##2 rd && addr == 8'h16 |=> rdata == $past(wdata, 3))
    else $error("control readback wrong");
  a_period_readback: assert property (wr && addr == 8'h18 ##2 rd && addr == 8'h18 |=> rdata == $past(wdata, 3))
    else $error("period readback wrong");
  // A stop write clears the live count two cycles later, without waiting for a tick
  a_stop_clears: assert property (wr && addr == 8'h16 && !wdata[3] && wdata[2:0] != 3'h3 ##2 rd && addr == 8'h1e
    |=> rdata == 8'h00)
    else $error("count not cleared by stop");
  // Output level loaded on start; window allows for the registered path
  a_flop_high: assert property (wr && addr == 8'h16 && wdata[3] && wdata[7] && wdata[2:0] == 3'h1
    |-> ##[1:3] timer_a_out)
    else $error("output not loaded high");
  a_flop_low: assert property (wr && addr == 8'h16 && wdata[3] && !wdata[7] && wdata[2:0] == 3'h1
    |-> ##[1:3] !timer_a_out)
    else $error("output not loaded low");
  a_mask_off: assert property (wr && addr == 8'h1d && wdata == 8'h00 |-> ##2 !irq)
    else $error("irq high with empty mask");
  a_reset_quiet: assert property ($fell(rst) |-> rdata == 8'h00 && !irq && !timer_a_out)
    else $error("outputs not idle after reset");
endmodule : dual_timer_checker
bind dual_timer dual_timer_checker u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .timer_a_out(timer_a_out),
  .irq(irq)
);
`default_nettype wire

// file: tb_dual_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dual_timer;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow_osc_clock = 1'b0;
  logic timer_a_pin = 1'b0;
  logic timer_b_pin = 1'b0;
  logic divider_tap_select = 1'b0;
  logic low_speed = 1'b0;
  logic [7:0] rdata;
  logic timer_a_out;
  logic timer_b_out;
  logic irq;
  int errCount = 0;
  int nChecks = 0;
  int cyc = 0;
  int gapTab[8] = '{2048, 128, 32, 8, 16, 2, 1, 4};
  always #5 core_clk = ~core_clk;
  // Slow oscillator period 16, pin A period 4, pin B period 8
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    slow_osc_clock <= cyc[3];
    timer_a_pin <= cyc[1];
    timer_b_pin <= cyc[2];
  end
  dual_timer u_dut (
    .core_clk(core_clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .slow_osc_clock(slow_osc_clock),
    .timer_a_pin(timer_a_pin),
    .timer_b_pin(timer_b_pin),
    .divider_tap_select(divider_tap_select),
    .low_speed(low_speed),
    .timer_a_out(timer_a_out),
    .timer_b_out(timer_b_out),
    .irq(irq)
  );
  task finish_test;
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  // Third toggle spacing; earlier ones may carry start phase
  task gap(input bit b, input int exp);
    int n;
    logic v;
    #1;
    for (int k = 0; k < 3; k++)
    begin
      v = b ? timer_b_out : timer_a_out;
      n = 0;
      while ((b ? timer_b_out : timer_a_out) === v && n < 5000)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
    end
    // Full-width compare; an 8-bit cut would hide a doubled prescaler
    nChecks++;
    if (n != exp)
    begin
      errCount++;
      $display("BAD %0t gap %0d exp %0d", $time, n, exp);
    end
  endtask : gap
  // Watchdog well past the expected run
  initial
  begin
    repeat (60000) @(posedge core_clk);
    errCount++;
    $display("BAD %0t timeout", $time);
    finish_test;
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd_chk(8'h16 + 8'(i), i < 2 ? 8'h00 : 8'hff);
    wr_reg(8'h10, 8'h55);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h20, 8'h00);
    wr_reg(8'h1a, 8'ha5);
    rd_chk(8'h1a, 8'ha5);
    wr_reg(8'h18, 8'h00);
    rd_chk(8'h18, 8'h00);
    // Every source, divider output, period 0
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(8'h16, {1'b0, 3'(i), 4'h9});
      gap(0, gapTab[i]);
      wr_reg(8'h16, {1'b0, 3'(i), 4'h1});
    end
    for (int j = 1; j < 3; j++)
    begin
      {divider_tap_select, low_speed} <= 2'(j);
      wr_reg(8'h16, 8'h09);
      gap(0, 128);
      wr_reg(8'h16, 8'h01);
    end
    {divider_tap_select, low_speed} <= 2'b00;
    // Period 3 gives four ticks per event
    wr_reg(8'h18, 8'h03);
    wr_reg(8'h16, 8'he9);
    gap(0, 4);
    wr_reg(8'h16, 8'he1);
    wr_reg(8'h1a, 8'h01);
    wr_reg(8'h16, 8'h6a);
    gap(0, 4);
    wr_reg(8'h1a, 8'h02);
    gap(0, 4);
    wr_reg(8'h16, 8'h62);
    rd_chk(8'h1e, 8'h00);
    // Sticky status, mask, clear
    wr_reg(8'h16, 8'h68);
    repeat (20) @(posedge core_clk);
    wr_reg(8'h16, 8'h60);
    rd_chk(8'h1c, 8'h01);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'h1d, 8'h01);
    repeat (3) @(posedge core_clk);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr_reg(8'h1c, 8'h01);
    rd_chk(8'h1c, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // Cascade: run comes from the second unit
    wr_reg(8'h18, 8'h01);
    wr_reg(8'h19, 8'h02);
    wr_reg(8'h16, 8'h6b);
    rd_chk(8'h16, 8'h6b);
    repeat (20) @(posedge core_clk);
    rd_chk(8'h1e, 8'h00);
    wr_reg(8'h17, 8'h0c);
    gap(1, 6);
    wr_reg(8'h17, 8'h04);
    // Upper-half overflows set bit 1 only; the mask alone decides the pin
    rd_chk(8'h1c, 8'h02);
    wr_reg(8'h1d, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr_reg(8'h1d, 8'h00);
    #1;
    chk({7'h0, irq}, 8'h00);
    finish_test;
  end
endmodule : tb_dual_timer
`default_nettype wire
